// ### rtl/hmi_dev.sv
// Purpose: interrupt aggregation, selftest code RAM, bypass and chassis reset
// Assumes: one access per bus_wr/bus_rd cycle; limit events arrive as pulses
// Notes: monitoring loop is a fixed-period tick; pins sync through two flops
// Operation
// - limit violations raise interrupt events
// - over 32 code writes: interrupt except on loop tick, pointer holds
// - low overtemp input is an interrupt source
// - high chassis input is a source, latched outside
// - mask2 bit7 pulls chassis low 20 ms
// - low chained input is an interrupt source
// - every source has a status flag
// - per-output mask registers gate flags
// - config enables outputs, selects NMI mode
// - status read returns then clears flags
// - reread before loop shows cleared flags
// - cleared flags deassert outputs until loop
// - config bit3 clears outputs, halts loop
// - config bit6 drives bypass output low
// - code port writes store byte, advance pointer
// - code RAM readable at index 00h-1Fh
// - data port reads use separate read pointer
// - test mode after reset, forced sysmgmt low
// - test mode releases all but listed pins
// - tree pin toggle shows on tree output
// - status1 access advances index to status2
//
// The APB register port and the register offsets were left to the implementer.
`include "hmi_regs.svh"
module hmi_dev (
  input wire logic pclk,
  input wire logic presetn,
  hmi_if.dev lnk,
  input wire logic [15:0] limit_evt,
  input wire logic sysmgmt_force_n,
  output logic test_mode_q
);
  logic [7:0] cfg_q, smask1_q, smask2_q, nmask1_q, nmask2_q, stat1_q, stat2_q, rdata_q;
  logic [15:0] pend_q;
  logic [6:0] idx_q;
  logic [4:0] wptr_q, rptr_q;
  logic wfull_q, cfg_written_q, smi_q, nmi_q, nmi_pulse_q, ci_oe_q, byp_q, tree_q;
  logic [7:0] selftest_code_mem [0:`HMI_SELFTEST_CODE_DEPTH-1];
  logic [2:0] s1_q, s2_q;
  logic [31:0] loop_q, ci_q;
  logic tick, rd_data, wr_data, wr_selftest_code, clr1, clr2, hold, selftest_code_ovf;

  // Pin inputs pass two flops before use
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      // Idle pin levels, so no false source follows reset
      s1_q <= 3'b101;
      s2_q <= 3'b101;
    end
    else
    begin
      s1_q <= {lnk.board_overtemp_input_n, lnk.chassis_in, lnk.chained_sysmgmt_input_n};
      s2_q <= s1_q;
    end
  end

  assign hold = cfg_q[`HMI_CFG_HOLD];
  assign rd_data = lnk.bus_rd && lnk.bus_port == hmi_pkg::HMI_P_DATA;
  assign wr_data = lnk.bus_wr && lnk.bus_port == hmi_pkg::HMI_P_DATA;
  assign wr_selftest_code = lnk.bus_wr && (lnk.bus_port == hmi_pkg::HMI_P_POST0 || lnk.bus_port == hmi_pkg::HMI_P_POST4);
  assign clr1 = (rd_data || wr_data) && idx_q == `HMI_IDX_STAT1;
  assign clr2 = (rd_data || wr_data) && idx_q == `HMI_IDX_STAT2;
  assign selftest_code_ovf = wr_selftest_code && wfull_q;
  assign tick = loop_q == 32'd0 && !hold;

  // Monitoring loop period; stops while hold bit is high
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      loop_q <= 32'd0;
    else if (hold)
      loop_q <= loop_q;
    else if (loop_q == 32'd0)
      loop_q <= `HMI_LOOP_CYC - 1;
    else
      loop_q <= loop_q - 32'd1;
  end

  // Pending events collected between loop evaluations
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pend_q <= 16'h0000;
    else if (tick)
      pend_q <= {limit_evt[15:12], 1'b0, 1'b0, 1'b0, limit_evt[8], limit_evt[7:6], 1'b0, limit_evt[4:0]};
    else
      pend_q <= pend_q | limit_evt | {13'd0, selftest_code_ovf, 2'b00} << 8;
  end

  // Status flags: set at loop tick, cleared by access; set wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stat1_q <= 8'h00;
      stat2_q <= 8'h00;
    end
    else
    begin
      if (tick)
      begin
        stat1_q <= (clr1 ? 8'h00 : stat1_q) | pend_q[7:0] | {2'b00, ~s2_q[2], 5'b00000};
        stat2_q <= (clr2 ? 8'h00 : stat2_q) | pend_q[15:8] | {4'b0000, ~s2_q[0], 1'b0, s2_q[1], 1'b0};
      end
      else
      begin
        if (clr1)
          stat1_q <= 8'h00;
        if (clr2)
          stat2_q <= 8'h00;
      end
    end
  end

  // Configuration and mask registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_q <= `HMI_CFG_RST;
      smask1_q <= 8'h00;
      smask2_q <= 8'h00;
      nmask1_q <= 8'h00;
      nmask2_q <= `HMI_NMASK2_RST;
      cfg_written_q <= 1'b0;
    end
    else
    begin
      if (ci_q == 32'd1)
        nmask2_q[`HMI_NMASK2_CIRST] <= 1'b0;
      if (wr_data)
        case (idx_q)
          `HMI_IDX_CFG:
          begin
            cfg_q <= lnk.bus_wdata;
            cfg_written_q <= 1'b1;
          end
          `HMI_IDX_SMASK1: smask1_q <= lnk.bus_wdata;
          `HMI_IDX_SMASK2: smask2_q <= lnk.bus_wdata;
          `HMI_IDX_NMASK1: nmask1_q <= lnk.bus_wdata;
          `HMI_IDX_NMASK2: nmask2_q <= lnk.bus_wdata;
          default: ;
        endcase
    end
  end

  // Chassis reset pulse counter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ci_q <= 32'd0;
    else if (wr_data && idx_q == `HMI_IDX_NMASK2 && lnk.bus_wdata[`HMI_NMASK2_CIRST])
      ci_q <= `HMI_CIRST_CYC;
    else if (ci_q != 32'd0)
      ci_q <= ci_q - 32'd1;
  end

  // Index pointer with auto-increment
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      idx_q <= 7'h00;
    else if (lnk.bus_wr && lnk.bus_port == hmi_pkg::HMI_P_ADDR)
      idx_q <= lnk.bus_wdata[6:0];
    else if ((rd_data || wr_data) && (idx_q == `HMI_IDX_STAT1 || idx_q == `HMI_IDX_SMASK1 || idx_q == `HMI_IDX_NMASK1))
      idx_q <= idx_q + 7'd1;
    else if ((rd_data || wr_data) && idx_q < `HMI_IDX_SELFTEST_CODE_LAST)
      idx_q <= idx_q + 7'd1;
  end

  // Code RAM: write pointer from code ports, read pointer from data port
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wptr_q <= 5'd0;
      wfull_q <= 1'b0;
      rptr_q <= 5'd0;
    end
    else
    begin
      if (wr_selftest_code && !wfull_q)
      begin
        wptr_q <= wptr_q + 5'd1;
        if (wptr_q == 5'd31)
          wfull_q <= 1'b1;
      end
      if (lnk.bus_wr && lnk.bus_port == hmi_pkg::HMI_P_ADDR)
        rptr_q <= lnk.bus_wdata[4:0];
      else if (rd_data && idx_q <= `HMI_IDX_SELFTEST_CODE_LAST && rptr_q != 5'd31)
        rptr_q <= rptr_q + 5'd1;
    end
  end

  always_ff @(posedge pclk)
  begin
    if (wr_selftest_code && !wfull_q)
      selftest_code_mem[wptr_q] <= lnk.bus_wdata;
  end

  // Read data mux
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rdata_q <= 8'h00;
    else if (lnk.bus_rd && lnk.bus_port == hmi_pkg::HMI_P_ADDR)
      rdata_q <= {1'b0, idx_q};
    else if (rd_data)
      case (idx_q)
        `HMI_IDX_CFG: rdata_q <= cfg_q;
        `HMI_IDX_STAT1: rdata_q <= stat1_q;
        `HMI_IDX_STAT2: rdata_q <= stat2_q;
        `HMI_IDX_SMASK1: rdata_q <= smask1_q;
        `HMI_IDX_SMASK2: rdata_q <= smask2_q;
        `HMI_IDX_NMASK1: rdata_q <= nmask1_q;
        `HMI_IDX_NMASK2: rdata_q <= nmask2_q;
        default: rdata_q <= idx_q <= `HMI_IDX_SELFTEST_CODE_LAST ? selftest_code_mem[rptr_q] : 8'h00;
      endcase
  end

  // Interrupt outputs; mask bit set blocks the flag
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      smi_q <= 1'b1;
      nmi_q <= 1'b1;
      nmi_pulse_q <= 1'b0;
    end
    else
    begin
      smi_q <= !(cfg_q[`HMI_CFG_SMI_EN] && !hold &&
        (|(stat1_q & ~smask1_q) || |(stat2_q & ~smask2_q)));
      // Pulse mode gives a single low cycle per loop tick with pending flags
      nmi_pulse_q <= tick;
      if (!cfg_q[`HMI_CFG_NMI_EN] || hold)
        nmi_q <= 1'b1;
      else if (cfg_q[`HMI_CFG_NMI_MODE])
        nmi_q <= !(nmi_pulse_q && (|(stat1_q & ~nmask1_q) || |(stat2_q & ~nmask2_q)));
      else
        nmi_q <= !(|(stat1_q & ~nmask1_q) || |(stat2_q & ~nmask2_q));
    end
  end

  // Test mode entry and outputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      test_mode_q <= 1'b0;
      ci_oe_q <= 1'b0;
      byp_q <= 1'b0;
      tree_q <= 1'b0;
    end
    else
    begin
      if (!cfg_written_q && !cfg_q[`HMI_CFG_START] && hold && !sysmgmt_force_n)
        test_mode_q <= 1'b1;
      ci_oe_q <= ci_q != 32'd0 && !test_mode_q;
      byp_q <= cfg_q[`HMI_CFG_BYPASS];
      tree_q <= ~&{s2_q[2], s2_q[0], s2_q[1]};
    end
  end

  assign lnk.bus_rdata = rdata_q;
  assign lnk.chassis_oe = ci_oe_q;
  assign lnk.sysmgmt_irq_output_n = test_mode_q ? 1'b1 : smi_q;
  assign lnk.nmi_irq_n = test_mode_q ? 1'b1 : nmi_q;
  assign lnk.bypass_oe = byp_q;
  assign lnk.tree_test_output = test_mode_q & tree_q;
endmodule // hmi_dev

// ### rtl/hmi_regs.svh
`ifndef HMI_REGS_SVH
`define HMI_REGS_SVH
// Internal index map of the device
`define HMI_IDX_CFG 7'h40
`define HMI_IDX_STAT1 7'h41
`define HMI_IDX_STAT2 7'h42
`define HMI_IDX_SMASK1 7'h43
`define HMI_IDX_SMASK2 7'h44
`define HMI_IDX_NMASK1 7'h45
`define HMI_IDX_NMASK2 7'h46
`define HMI_IDX_SELFTEST_CODE_LAST 7'h1F
`define HMI_CFG_RST 8'h08
`define HMI_NMASK2_RST 8'h40
`define HMI_CFG_START 0
`define HMI_CFG_SMI_EN 1
`define HMI_CFG_NMI_EN 2
`define HMI_CFG_HOLD 3
`define HMI_CFG_NMI_MODE 5
`define HMI_CFG_BYPASS 6
`define HMI_NMASK2_CIRST 7
`define HMI_SELFTEST_CODE_DEPTH 32
// Status 1 bits: 0..3 analog, 4 temp, 5 overtemp input, 6 fan1, 7 fan2
`define HMI_S1_BTI 5
// Status 2 bits: 0 fan3, 1 chassis, 2 selftest_code overflow, 3 chained input, 4..7 analog
`define HMI_S2_CHAS 1
`define HMI_S2_SELFTEST_CODE 2
`define HMI_S2_SMIIN 3
// Timing at 40 MHz
`define HMI_CLK_HZ 40000000
`define HMI_CIRST_MS 20
`define HMI_CIRST_CYC ((`HMI_CLK_HZ / 1000) * `HMI_CIRST_MS)
`define HMI_LOOP_CYC 4000
// Host register offsets on APB
`define HMI_APB_CMD 12'h000
`define HMI_APB_WDATA 12'h004
`define HMI_APB_RDATA 12'h008
`define HMI_APB_STATUS 12'h00C
`define HMI_APB_PINS 12'h010
`define HMI_CMD_GO 8
`define HMI_CMD_WR 9
`endif

// ### rtl/hmi_pkg.sv
package hmi_pkg;
  typedef enum logic [1:0] {HMI_IDLE_ST = 2'b00, HMI_SETUP_ST = 2'b01, HMI_DONE_ST = 2'b11} hmi_state_type;
  typedef enum logic [1:0] {HMI_P_ADDR = 2'b00, HMI_P_DATA = 2'b01, HMI_P_POST0 = 2'b10, HMI_P_POST4 = 2'b11} hmi_port_type;
endpackage

// ### rtl/hmi_if.sv
// Purpose: link between hardware monitor interrupt logic and its host
// Assumes: single clock pclk, register port sampled per cycle
// Notes: chassis line is open drain; level resolved here
interface hmi_if (input wire logic pclk);
  logic bus_wr;
  logic bus_rd;
  logic [1:0] bus_port;
  logic [7:0] bus_wdata;
  logic [7:0] bus_rdata;
  logic board_overtemp_input_n;
  logic chained_sysmgmt_input_n;
  logic chassis_ext;
  logic chassis_oe;
  logic chassis_in;
  logic sysmgmt_irq_output_n;
  logic nmi_irq_n;
  logic bypass_oe;
  logic tree_test_output;
  assign chassis_in = chassis_ext & ~chassis_oe;
  modport dev (input bus_wr, input bus_rd, input bus_port, input bus_wdata, output bus_rdata,
    input board_overtemp_input_n, input chained_sysmgmt_input_n, input chassis_in, output chassis_oe,
    output sysmgmt_irq_output_n, output nmi_irq_n, output bypass_oe, output tree_test_output);
  modport host (output bus_wr, output bus_rd, output bus_port, output bus_wdata, input bus_rdata,
    output board_overtemp_input_n, output chained_sysmgmt_input_n, output chassis_ext, input chassis_oe,
    input sysmgmt_irq_output_n, input nmi_irq_n, input bypass_oe, input tree_test_output);
endinterface

// ### rtl/hmi_host.sv
// Purpose: host end; APB slave that drives the device register port
// Assumes: software issues one command at a time, polls busy
// Notes: each device access takes two pclk cycles; result read back
`include "hmi_regs.svh"
module hmi_host (
  input wire logic pclk,
  input wire logic presetn,
  hmi_if.host lnk,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  hmi_pkg::hmi_state_type st_q;
  logic [9:0] cmd_q;
  logic [7:0] res_q;
  logic [7:0] wdat_q;
  logic [2:0] pins_q;
  logic [1:0] irq_s1_q, irq_s2_q;
  logic wr_q, rd_q, acc;
  assign acc = psel && penable;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_s1_q <= 2'b11;
      irq_s2_q <= 2'b11;
    end
    else
    begin
      irq_s1_q <= {lnk.sysmgmt_irq_output_n, lnk.nmi_irq_n};
      irq_s2_q <= irq_s1_q;
    end
  end

  // Data byte kept apart from the port field so any index is reachable
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wdat_q <= 8'h00;
    else if (acc && pwrite && paddr == `HMI_APB_WDATA)
      wdat_q <= pwdata[7:0];
  end

  // External lines: bit0 overtemp_n, bit1 chained_n, bit2 chassis
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pins_q <= 3'b011;
      cmd_q <= 10'h000;
    end
    else if (acc && pwrite && paddr == `HMI_APB_PINS)
      pins_q <= pwdata[2:0];
    else if (acc && pwrite && paddr == `HMI_APB_CMD && st_q == hmi_pkg::HMI_IDLE_ST)
      cmd_q <= pwdata[9:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q <= hmi_pkg::HMI_IDLE_ST;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      res_q <= 8'h00;
    end
    else
      case (st_q)
        hmi_pkg::HMI_IDLE_ST:
          if (acc && pwrite && paddr == `HMI_APB_CMD && pwdata[`HMI_CMD_GO])
          begin
            st_q <= hmi_pkg::HMI_SETUP_ST;
            wr_q <= pwdata[`HMI_CMD_WR];
            rd_q <= !pwdata[`HMI_CMD_WR];
          end
        hmi_pkg::HMI_SETUP_ST:
        begin
          wr_q <= 1'b0;
          rd_q <= 1'b0;
          st_q <= hmi_pkg::HMI_DONE_ST;
        end
        hmi_pkg::HMI_DONE_ST:
        begin
          res_q <= lnk.bus_rdata;
          st_q <= hmi_pkg::HMI_IDLE_ST;
        end
        default: st_q <= hmi_pkg::HMI_IDLE_ST;
      endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable && !pwrite)
        case (paddr)
          `HMI_APB_CMD: prdata <= {22'd0, cmd_q};
          `HMI_APB_RDATA: prdata <= {24'd0, res_q};
          `HMI_APB_STATUS: prdata <= {28'd0, irq_s2_q, 1'b0, st_q != hmi_pkg::HMI_IDLE_ST};
          `HMI_APB_PINS: prdata <= {26'd0, lnk.tree_test_output, lnk.bypass_oe, lnk.chassis_oe, pins_q};
          default: prdata <= 32'h0000_0000;
        endcase
      else if (psel && !penable)
        pslverr <= !(paddr == `HMI_APB_CMD || paddr == `HMI_APB_WDATA || paddr == `HMI_APB_PINS);
    end
  end

  assign lnk.bus_wr = wr_q;
  assign lnk.bus_rd = rd_q;
  assign lnk.bus_port = cmd_q[1:0];
  assign lnk.bus_wdata = wdat_q;
  assign lnk.board_overtemp_input_n = pins_q[0];
  assign lnk.chained_sysmgmt_input_n = pins_q[1];
  assign lnk.chassis_ext = pins_q[2];
endmodule // hmi_host

// ### test/hmi_link_monitor.sv
// Purpose: link checker for hmi interrupt logic
// Assumes: cfg reached by index then data port
// Notes: shadow cfg; 7 cycles slack after writes
`include "hmi_regs.svh"
module hmi_link_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [1:0] bus_port,
  input wire logic [7:0] bus_wdata,
  input wire logic [7:0] bus_rdata,
  input wire logic sysmgmt_irq_output_n,
  input wire logic nmi_irq_n,
  input wire logic bypass_oe,
  input wire logic chassis_oe
);
  logic [6:0] idx_q;
  logic [7:0] cfg_q;
  logic [2:0] age_q;
  logic [19:0] oe_cnt_q;
  logic quiet;
  logic inc;
  assign quiet = age_q == 3'h7;
  assign inc = idx_q < 7'h1F || idx_q == 7'h41 || idx_q == 7'h43 || idx_q == 7'h45;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      idx_q <= 7'h00;
    else if (bus_wr && bus_port == 2'h0)
      idx_q <= bus_wdata[6:0];
    else if ((bus_wr || bus_rd) && bus_port == 2'h1 && inc)
      idx_q <= idx_q + 7'h01;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cfg_q <= `HMI_CFG_RST;
    else if (bus_wr && bus_port == 2'h1 && idx_q == `HMI_IDX_CFG)
      cfg_q <= bus_wdata;
  end
  // Output flops lag a write, so judge only once settled
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      age_q <= 3'h0;
    else if (bus_wr)
      age_q <= 3'h0;
    else if (!quiet)
      age_q <= age_q + 3'h1;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      oe_cnt_q <= 20'h0_0000;
    else if (!chassis_oe)
      oe_cnt_q <= 20'h0_0000;
    else if (oe_cnt_q != 20'hF_FFFF)
      oe_cnt_q <= oe_cnt_q + 20'h0_0001;
  end
  property p_strobe_one;
    (bus_wr || bus_rd) |=> !(bus_wr || bus_rd);
  endproperty
  a_strobe_one: assert property (p_strobe_one)
    else $error("bus strobe held too long");
  property p_strobe_excl;
    !(bus_wr && bus_rd);
  endproperty
  a_strobe_excl: assert property (p_strobe_excl)
    else $error("read and write strobes together");
  property p_rd_answer;
    $changed(bus_rdata) |-> $past(bus_rd);
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read data moved without a read");
  property p_bypass;
    quiet |-> bypass_oe == cfg_q[`HMI_CFG_BYPASS];
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("bypass output disagrees with cfg");
  property p_hold;
    quiet && cfg_q[`HMI_CFG_HOLD] |-> nmi_irq_n && sysmgmt_irq_output_n;
  endproperty
  a_hold: assert property (p_hold)
    else $error("irq output active while held");
  property p_nmi_off;
    quiet && !cfg_q[`HMI_CFG_NMI_EN] |-> nmi_irq_n;
  endproperty
  a_nmi_off: assert property (p_nmi_off)
    else $error("nmi active while disabled");
  property p_smi_off;
    quiet && !cfg_q[`HMI_CFG_SMI_EN] |-> sysmgmt_irq_output_n;
  endproperty
  a_smi_off: assert property (p_smi_off)
    else $error("sysmgmt active while disabled");
  property p_nmi_pulse;
    quiet && cfg_q[`HMI_CFG_NMI_MODE] && $fell(nmi_irq_n) |=> nmi_irq_n;
  endproperty
  a_nmi_pulse: assert property (p_nmi_pulse)
    else $error("nmi pulse longer than one cycle");
  property p_chassis_len;
    $fell(chassis_oe) |-> oe_cnt_q >= `HMI_CIRST_CYC;
  endproperty
  a_chassis_len: assert property (p_chassis_len)
    else $error("chassis reset pulse too short");
endmodule // hmi_link_monitor

// ### test/hw_monitor_interrupt_logic_test.sv
// Purpose: bench for both hmi ends joined by the link
// Assumes: host end drives the external source pins idle
// Notes: each case starts from reset; data byte goes through WDATA
`include "hmi_regs.svh"
module hw_monitor_interrupt_logic_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic [15:0] limit_evt = '0;
  logic sysmgmt_force_n = 1'b1;
  logic test_mode;
  int n_fail = 0;
  int compares = 0;
  always #12.5 pclk = ~pclk;
  hmi_if lnk (.pclk(pclk));
  hmi_dev hmi_dev_i (.pclk(pclk), .presetn(presetn), .lnk(lnk.dev), .limit_evt(limit_evt),
    .sysmgmt_force_n(sysmgmt_force_n), .test_mode_q(test_mode));
  hmi_host hmi_host_i (.pclk(pclk), .presetn(presetn), .lnk(lnk.host), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr());
  hmi_link_monitor hmi_link_monitor_i (.pclk(pclk), .presetn(presetn), .bus_wr(lnk.bus_wr),
    .bus_rd(lnk.bus_rd), .bus_port(lnk.bus_port), .bus_wdata(lnk.bus_wdata), .bus_rdata(lnk.bus_rdata),
    .sysmgmt_irq_output_n(lnk.sysmgmt_irq_output_n), .nmi_irq_n(lnk.nmi_irq_n),
    .bypass_oe(lnk.bypass_oe), .chassis_oe(lnk.chassis_oe));
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Idle edge first, so release and next setup never share a time step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      if (++n > 50)
      begin
        chk("pready", 0, 1);
        tally_and_finish;
      end
      @(posedge pclk);
    end
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic dev_acc(input logic w, input logic [1:0] p, input logic [7:0] b, output logic [7:0] r);
    logic [31:0] v;
    int n;
    n = 0;
    apb(1'b1, `HMI_APB_WDATA, {24'h00_0000, b}, v);
    apb(1'b1, `HMI_APB_CMD, {22'h00_0000, w, 1'b1, 6'h00, p}, v);
    do
    begin
      apb(1'b0, `HMI_APB_STATUS, '0, v);
      n++;
    end while (v[0] !== 1'b0 && n < 20);
    chk("busy", v[0], 0);
    apb(1'b0, `HMI_APB_RDATA, '0, v);
    r = v[7:0];
  endtask
  // Low bits of the byte also pick the device port
  task automatic dev_op(input logic w, input logic [7:0] b, output logic [7:0] r);
    dev_acc(w, b[1:0], b, r);
  endtask
  task automatic set_cfg(input logic [7:0] c);
    logic [7:0] r;
    dev_op(1'b1, 8'h40, r);
    dev_op(1'b1, c, r);
  endtask
  task automatic see_nmi(input logic lvl, input int lim, input bit stay);
    int n;
    for (n = 0; n < lim; n++)
    begin
      @(negedge pclk);
      if (stay ? lnk.nmi_irq_n !== lvl : lnk.nmi_irq_n === lvl)
        break;
    end
    chk(stay ? "nmi held" : "nmi reached", stay ? n == lim : n < lim, 1);
  endtask
  task automatic do_reset;
    presetn <= 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  function automatic logic [7:0] code(input int i);
    return {i[5:0], 1'b1, i[0]};
  endfunction
  task automatic t_reset;
    logic [7:0] r;
    @(negedge pclk);
    chk("nmi idle", lnk.nmi_irq_n, 1);
    chk("smi idle", lnk.sysmgmt_irq_output_n, 1);
    chk("chassis oe", lnk.chassis_oe, 0);
    dev_op(1'b1, 8'h40, r);
    dev_op(1'b0, 8'h01, r);
    chk("cfg reset", r, `HMI_CFG_RST);
    set_cfg(8'h41);
    chk("bypass on", lnk.bypass_oe, 1);
    dev_op(1'b0, 8'h01, r);
    chk("cfg back", r, 8'h41);
    set_cfg(8'h01);
    chk("bypass off", lnk.bypass_oe, 0);
  endtask
  task automatic t_test;
    logic [31:0] v;
    do_reset;
    sysmgmt_force_n <= 1'b0;
    repeat (3) @(posedge pclk);
    sysmgmt_force_n <= 1'b1;
    @(negedge pclk);
    chk("test mode", test_mode, 1);
    chk("smi released", lnk.sysmgmt_irq_output_n, 1);
    apb(1'b1, `HMI_APB_PINS, 32'h0000_0007, v);
    repeat (6) @(posedge pclk);
    @(negedge pclk);
    chk("tree idle", lnk.tree_test_output, 0);
    apb(1'b1, `HMI_APB_PINS, 32'h0000_0006, v);
    repeat (6) @(posedge pclk);
    @(negedge pclk);
    chk("tree toggle", lnk.tree_test_output, 1);
  endtask
  task automatic t_chassis;
    logic [7:0] r;
    do_reset;
    dev_acc(1'b1, 2'd0, 8'h46, r);
    dev_acc(1'b1, 2'd1, 8'hC0, r);
    chk("chassis pull", lnk.chassis_oe, 1);
    repeat (1000) @(posedge pclk);
    @(negedge pclk);
    chk("chassis hold", lnk.chassis_oe, 1);
  endtask
  task automatic t_limit(input int k);
    logic [7:0] r;
    do_reset;
    set_cfg(8'h05);
    see_nmi(1'b1, 4100, 1);
    @(posedge pclk);
    limit_evt[k] <= 1'b1;
    @(posedge pclk);
    limit_evt <= '0;
    see_nmi(1'b0, 4100, 0);
    set_cfg(8'h0D);
    see_nmi(1'b1, 20, 0);
    see_nmi(1'b1, 4100, 1);
    set_cfg(8'h05);
    see_nmi(1'b0, 4100, 0);
    set_cfg(8'h01);
    see_nmi(1'b1, 20, 0);
    set_cfg(8'h25);
    see_nmi(1'b0, 4100, 0);
    see_nmi(1'b1, 1, 0);
    dev_acc(1'b1, 2'd0, 8'h41, r);
    dev_acc(1'b0, 2'd1, 8'h00, r);
    chk("stat1", r, (32'd1 << k) & 32'h0000_00FF);
    dev_acc(1'b0, 2'd1, 8'h00, r);
    chk("stat2", r, (32'd1 << k) >> 8);
    dev_acc(1'b1, 2'd0, 8'h41, r);
    dev_acc(1'b0, 2'd1, 8'h00, r);
    chk("stat1 reread", r, 0);
    see_nmi(1'b1, 4100, 1);
  endtask
  task automatic t_selftest_code;
    logic [7:0] r;
    do_reset;
    for (int i = 0; i < `HMI_SELFTEST_CODE_DEPTH; i++)
      dev_op(1'b1, code(i), r);
    set_cfg(8'h05);
    see_nmi(1'b1, 4100, 1);
    dev_op(1'b1, 8'h00, r);
    for (int i = 0; i < `HMI_SELFTEST_CODE_DEPTH; i++)
    begin
      dev_op(1'b0, 8'h01, r);
      chk("code ram", r, code(i));
    end
    dev_op(1'b1, 8'hFF, r);
    see_nmi(1'b0, 4100, 0);
  endtask
  initial
  begin
    do_reset;
    t_reset;
    t_test;
    t_chassis;
    t_limit(0);
    t_limit(15);
    t_selftest_code;
    tally_and_finish;
  end
endmodule // hw_monitor_interrupt_logic_test
